// >>> src/pcg_cfg.svh
// Constants for the pulse and capture group: selector codes and resets.
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH

// ----------------------------------------------------------------------
// Divider ratio codes.
// ----------------------------------------------------------------------
`define PCG_DIV_1   3'h0
`define PCG_DIV_2   3'h1
`define PCG_DIV_4   3'h2
`define PCG_DIV_8   3'h3
`define PCG_DIV_16  3'h4

// ----------------------------------------------------------------------
// Widths and reset values.
// ----------------------------------------------------------------------
`define PCG_CNT_W     16
`define PCG_PRE_W     8
`define PCG_DZ_W      8
`define PCG_CHANS     4
`define PCG_PAIRS     2
`define PCG_PRE_RST   8'h00
`define PCG_DIVC_RST  4'h0

`endif

// >>> src/pcg_pkg.sv
// Types shared by the pulse and capture group modules.
package pcg_pkg;

	// ------------------------------------------------------------------
	// Per-channel configuration and per-channel event bundle.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        enable;
		logic        auto_reload;
		logic        updown;
		logic [2:0]  div_sel;
		logic [15:0] period;
		logic [15:0] duty;
		logic        cap_mode;
		logic        cap_rise_lat;
		logic        cap_fall_lat;
		logic        per_ie;
		logic        irq_on_duty;
		logic        cap_rise_ie;
		logic        cap_fall_ie;
		logic        dma_en;
		logic        adc_trig_en;
	} pcg_chan_cfg_t;

	typedef struct packed {
		logic zero;
		logic duty;
		logic centre;
		logic cap_rise;
		logic cap_fall;
		logic cap_latch;
	} pcg_chan_ev_t;

	typedef enum logic [1:0] {
		PCG_IDLE,
		PCG_RUN,
		PCG_DONE
	} pcg_run_t;

endpackage

// >>> src/pcg_chan.sv
// One channel timer: divider, period counter, duty compare and capture.
`timescale 1ns/10ps
`include "pcg_cfg.svh"
`default_nettype none
module pcg_chan #(
	parameter int CNT_W = `PCG_CNT_W
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire logic                  pre_tick,
	input  wire pcg_pkg::pcg_chan_cfg_t cfg,
	input  wire logic                  pin_in,
	output var  logic                  wave,
	output var  logic                  running,
	output var  pcg_pkg::pcg_chan_ev_t ev,
	output var  logic [CNT_W-1:0]      cap_val
);

	// ------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------
	pcg_pkg::pcg_run_t     st_r, st_nxt;
	logic [CNT_W-1:0]      cnt_r, cnt_nxt, cap_nxt;
	logic                  up_r, up_nxt, pin_r, wave_nxt;
	logic [3:0]            div_r, div_nxt, mask;
	logic                  tick, rise, fall;
	pcg_pkg::pcg_chan_ev_t ev_nxt;

	always_comb begin
		mask     = 4'((5'h01 << cfg.div_sel) - 5'h01);
		tick     = pre_tick && ((div_r & mask) == mask);
		div_nxt  = pre_tick ? div_r + 4'h1 : div_r;
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		up_nxt   = up_r;
		ev_nxt   = '0;
		case (st_r)
			pcg_pkg::PCG_IDLE: begin
				div_nxt = `PCG_DIVC_RST;
				if (cfg.enable) begin
					st_nxt  = pcg_pkg::PCG_RUN;
					cnt_nxt = cfg.updown ? '0 : cfg.period;
					up_nxt  = 1'b1;
				end
			end
			pcg_pkg::PCG_RUN: begin
				if (!cfg.enable) begin
					st_nxt = pcg_pkg::PCG_IDLE;
				end else if (tick) begin
					if (cfg.updown && up_r) begin
						if (cnt_r >= cfg.period) begin
							up_nxt     = 1'b0;
							ev_nxt.centre = 1'b1;
							if (cnt_r != '0) begin
								cnt_nxt = cnt_r - 1'b1;
							end
						end else begin
							cnt_nxt = cnt_r + 1'b1;
						end
					end else if (cnt_r == '0) begin
						if (cfg.auto_reload) begin
							cnt_nxt = cfg.updown ? '0 : cfg.period;
							up_nxt  = 1'b1;
						end else begin
							st_nxt = pcg_pkg::PCG_DONE;
						end
					end else begin
						cnt_nxt = cnt_r - 1'b1;
						ev_nxt.zero = (cnt_nxt == '0);
					end
					ev_nxt.duty = (cnt_nxt == cfg.duty) && (cnt_nxt != cnt_r);
				end
			end
			pcg_pkg::PCG_DONE: begin
				if (!cfg.enable) begin
					st_nxt = pcg_pkg::PCG_IDLE;
				end
			end
			default: begin
				st_nxt = pcg_pkg::PCG_IDLE;
			end
		endcase
		wave_nxt = (st_nxt == pcg_pkg::PCG_RUN) && (cnt_nxt <= cfg.duty);
		rise     = cfg.cap_mode && pin_in && !pin_r;
		fall     = cfg.cap_mode && !pin_in && pin_r;
		ev_nxt.cap_rise  = rise;
		ev_nxt.cap_fall  = fall;
		ev_nxt.cap_latch = (rise && cfg.cap_rise_lat) ||
			(fall && cfg.cap_fall_lat);
		cap_nxt = ev_nxt.cap_latch ? cnt_r : cap_val;
	end

	// ------------------------------------------------------------------
	// State registers.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r    <= pcg_pkg::PCG_IDLE;
			cnt_r   <= '0;
			up_r    <= 1'b1;
			div_r   <= `PCG_DIVC_RST;
			pin_r   <= 1'b0;
			wave    <= 1'b0;
			running <= 1'b0;
			ev      <= '0;
			cap_val <= '0;
		end else if (clk_en) begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			up_r    <= up_nxt;
			div_r   <= div_nxt;
			pin_r   <= pin_in;
			wave    <= wave_nxt;
			running <= (st_nxt == pcg_pkg::PCG_RUN);
			ev      <= ev_nxt;
			cap_val <= cap_nxt;
		end
	end

endmodule
`default_nettype wire

// >>> src/pcg_top.sv
// Four-channel pulse generator group with dead zones and edge capture.
`timescale 1ns/10ps
`include "pcg_cfg.svh"
`default_nettype none
module pcg_top #(
	parameter int CNT_W = `PCG_CNT_W,
	parameter int PRE_W = `PCG_PRE_W,
	parameter int DZ_W  = `PCG_DZ_W
) (
	input  wire logic                   ref_clk,
	input  wire logic                   resetn,
	input  wire logic                   clk_en,
	input  wire logic [PRE_W-1:0]       pre_div,
	input  wire logic [1:0]             pair_comp,
	input  wire logic [1:0][DZ_W-1:0]   dz_len,
	input  wire pcg_pkg::pcg_chan_cfg_t [3:0] chan_cfg,
	input  wire logic [3:0]             per_flag_clr,
	input  wire logic [3:0]             cap_rise_clr,
	input  wire logic [3:0]             cap_fall_clr,
	input  wire logic [3:0]             pulse_in,
	output var  logic                   pulse_out_0,
	output var  logic                   pulse_out_1,
	output var  logic                   pulse_out_2,
	output var  logic                   pulse_out_3,
	output var  logic [3:0]             pulse_oe_n,
	output var  logic [3:0]             per_flag,
	output var  logic [3:0]             cap_rise_flag,
	output var  logic [3:0]             cap_fall_flag,
	output var  logic [3:0][CNT_W-1:0]  cap_value,
	output var  logic [3:0]             chan_running,
	output var  logic [3:0]             peripheral_dma_request,
	output var  logic                   adc_trigger,
	output var  logic                   irq
);

	// ------------------------------------------------------------------
	// Reset release.
	// ------------------------------------------------------------------
	logic rst_s1_r, rst_n_r;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ------------------------------------------------------------------
	// Prescaler.
	// ------------------------------------------------------------------
	logic [PRE_W-1:0] pre_r, pre_nxt;
	logic             pre_tick_r, pre_tick_nxt;

	always_comb begin
		pre_tick_nxt = 1'b0;
		pre_nxt      = pre_r + 1'b1;
		if (pre_nxt >= pre_div) begin
			pre_nxt      = '0;
			pre_tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pre_r      <= `PCG_PRE_RST;
			pre_tick_r <= 1'b0;
		end else if (clk_en) begin
			pre_r      <= pre_nxt;
			pre_tick_r <= pre_tick_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Channel timers.
	// ------------------------------------------------------------------
	logic [3:0]                  wave;
	pcg_pkg::pcg_chan_ev_t [3:0] ev;

	for (genvar c = 0; c < `PCG_CHANS; c++) begin : g_chan
		pcg_chan #(
			.CNT_W (CNT_W)
		) u_chan (
			.ref_clk  (ref_clk),
			.rst_n    (rst_n_r),
			.clk_en   (clk_en),
			.pre_tick (pre_tick_r),
			.cfg      (chan_cfg[c]),
			.pin_in   (pulse_in[c]),
			.wave     (wave[c]),
			.running  (chan_running[c]),
			.ev       (ev[c]),
			.cap_val  (cap_value[c])
		);
	end

	// ------------------------------------------------------------------
	// Pair outputs with dead-zone insertion.
	// ------------------------------------------------------------------
	logic [3:0] pin_drv;

	for (genvar p = 0; p < `PCG_PAIRS; p++) begin : g_pair
		logic [DZ_W-1:0] dz_r, dz_nxt;
		logic            last_r, last_nxt;
		logic            ev_r, ev_nxt, od_r, od_nxt;

		always_comb begin
			dz_nxt   = dz_r;
			last_nxt = wave[2*p];
			ev_nxt   = wave[2*p];
			od_nxt   = wave[2*p+1];
			if (pair_comp[p]) begin
				if (wave[2*p] != last_r) begin
					dz_nxt = dz_len[p];
					ev_nxt = 1'b0;
					od_nxt = 1'b0;
				end else if (dz_r != '0) begin
					dz_nxt = dz_r - 1'b1;
					ev_nxt = 1'b0;
					od_nxt = 1'b0;
				end else begin
					ev_nxt = wave[2*p];
					od_nxt = !wave[2*p];
				end
			end else begin
				dz_nxt = '0;
			end
		end

		always_ff @(posedge ref_clk or negedge rst_n_r) begin
			if (!rst_n_r) begin
				dz_r   <= '0;
				last_r <= 1'b0;
				ev_r   <= 1'b0;
				od_r   <= 1'b0;
			end else if (clk_en) begin
				dz_r   <= dz_nxt;
				last_r <= last_nxt;
				ev_r   <= ev_nxt;
				od_r   <= od_nxt;
			end
		end

		assign pin_drv[2*p]   = ev_r;
		assign pin_drv[2*p+1] = od_r;
	end

	assign pulse_out_0 = pin_drv[0];
	assign pulse_out_1 = pin_drv[1];
	assign pulse_out_2 = pin_drv[2];
	assign pulse_out_3 = pin_drv[3];

	// ------------------------------------------------------------------
	// Flags, interrupt, DMA and ADC trigger.
	// ------------------------------------------------------------------
	logic [3:0] per_nxt, rise_nxt, fall_nxt, dma_nxt, oe_nxt, per_set;
	logic       irq_nxt, adc_nxt;

	always_comb begin
		adc_nxt = 1'b0;
		for (int i = 0; i < 4; i++) begin
			per_set[i] = chan_cfg[i].irq_on_duty ? ev[i].duty
				: ev[i].zero;
			dma_nxt[i] = ev[i].cap_latch && chan_cfg[i].dma_en;
			oe_nxt[i]  = chan_cfg[i].cap_mode;
			adc_nxt    = adc_nxt || (ev[i].centre &&
				chan_cfg[i].adc_trig_en);
		end
		per_nxt  = (per_flag & ~per_flag_clr) | per_set;
		rise_nxt = (cap_rise_flag & ~cap_rise_clr) |
			{ev[3].cap_rise, ev[2].cap_rise, ev[1].cap_rise,
			ev[0].cap_rise};
		fall_nxt = (cap_fall_flag & ~cap_fall_clr) |
			{ev[3].cap_fall, ev[2].cap_fall, ev[1].cap_fall,
			ev[0].cap_fall};
		irq_nxt = 1'b0;
		for (int i = 0; i < 4; i++) begin
			irq_nxt = irq_nxt || (per_nxt[i] && chan_cfg[i].per_ie) ||
				(rise_nxt[i] && chan_cfg[i].cap_rise_ie) ||
				(fall_nxt[i] && chan_cfg[i].cap_fall_ie);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			per_flag               <= '0;
			cap_rise_flag          <= '0;
			cap_fall_flag          <= '0;
			peripheral_dma_request <= '0;
			pulse_oe_n             <= 4'hF;
			adc_trigger            <= 1'b0;
			irq                    <= 1'b0;
		end else if (clk_en) begin
			per_flag               <= per_nxt;
			cap_rise_flag          <= rise_nxt;
			cap_fall_flag          <= fall_nxt;
			peripheral_dma_request <= dma_nxt;
			pulse_oe_n             <= oe_nxt;
			adc_trigger            <= adc_nxt;
			irq                    <= irq_nxt;
		end
	end

endmodule
`default_nettype wire

// >>> dv/pcg_load_model.sv
// External load on the four pins: resolves drive and test stimulus.
`timescale 1ns/10ps
`default_nettype none
module pcg_load_model (
	input  wire logic [3:0] drive,
	input  wire logic [3:0] oe_n,
	input  wire logic [3:0] stim,
	output var  logic [3:0] pin
);
	// ----
	// Pin level
	// ----
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin[i] = oe_n[i] ? stim[i] : drive[i];
		end
	end
endmodule
`default_nettype wire

// >>> dv/pcg_top_monitor.sv
// Checker bound to the pulse and capture group top module.
`timescale 1ns/10ps
`default_nettype none
module pcg_top_monitor (
	input wire logic                         ref_clk,
	input wire logic                         resetn,
	input wire logic                         clk_en,
	input wire logic [1:0]                   pair_comp,
	input wire pcg_pkg::pcg_chan_cfg_t [3:0] chan_cfg,
	input wire logic [3:0]                   per_flag_clr,
	input wire logic [3:0]                   pulse_in,
	input wire logic                         pulse_out_0,
	input wire logic                         pulse_out_1,
	input wire logic [3:0]                   pulse_oe_n,
	input wire logic [3:0]                   per_flag,
	input wire logic [3:0]                   cap_rise_flag,
	input wire logic [3:0]                   cap_fall_flag,
	input wire logic [3:0]                   chan_running,
	input wire logic [3:0]                   peripheral_dma_request,
	input wire logic                         adc_trigger,
	input wire logic                         irq
);
	// ----
	// Helper logic
	// ----
	logic [1:0] age_r;
	logic [1:0] age_nxt;
	logic       live;
	logic [3:0] pie;
	logic [3:0] rie;
	logic [3:0] fie;
	always_comb begin
		age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
		for (int i = 0; i < 4; i++) begin
			pie[i] = chan_cfg[i].per_ie;
			rie[i] = chan_cfg[i].cap_rise_ie;
			fie[i] = chan_cfg[i].cap_fall_ie;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			age_r <= 2'h0;
		end else begin
			age_r <= age_nxt;
		end
	end
	assign live = (age_r == 2'h3);
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_run_after_enable: assert property (live && clk_en &&
		$rose(chan_cfg[0].enable) |=> chan_running[0])
		else $error("channel did not start after enable");
	a_oe_follows_mode: assert property (live && $past(clk_en) &&
		$stable(chan_cfg[2].cap_mode) |-> pulse_oe_n[2] == chan_cfg[2].cap_mode)
		else $error("output enable disagrees with pin mode");
	a_irq_enabled_flags: assert property (live && $past(clk_en) &&
		$stable(chan_cfg) |-> irq == |((per_flag & pie) |
		(cap_rise_flag & rie) | (cap_fall_flag & fie)))
		else $error("interrupt differs from enabled flags");
	a_flag_sticky: assert property (per_flag[0] && !per_flag_clr[0]
		|=> per_flag[0]) else $error("period flag lost without clear");
	a_dma_one_cycle: assert property (peripheral_dma_request[2]
		|=> !peripheral_dma_request[2]) else $error("dma request too long");
	a_adc_one_cycle: assert property (adc_trigger |=> !adc_trigger)
		else $error("adc trigger too long");
	a_pair_no_overlap: assert property (live && pair_comp[0] &&
		$past(pair_comp[0]) && $past(pair_comp[0], 3)
		|-> !(pulse_out_0 && pulse_out_1)) else $error("pair outputs overlap");
	a_idle_out_low: assert property ((!chan_running[0] &&
		!pair_comp[0])[*3] |-> !pulse_out_0)
		else $error("output high while stopped");
	a_capture_rise: assert property (live && clk_en &&
		chan_cfg[2].cap_mode && $past(chan_cfg[2].cap_mode) &&
		$rose(pulse_in[2]) |-> ##[1:2] cap_rise_flag[2])
		else $error("rising capture flag missing");
	c_pair: cover property (pair_comp[0] && pulse_out_1);
	c_dma: cover property (peripheral_dma_request[2]);
	c_adc: cover property (adc_trigger);
endmodule
bind pcg_top pcg_top_monitor u_mon (.ref_clk(ref_clk), .resetn(resetn),
	.clk_en(clk_en), .pair_comp(pair_comp), .chan_cfg(chan_cfg),
	.per_flag_clr(per_flag_clr), .pulse_in(pulse_in),
	.pulse_out_0(pulse_out_0), .pulse_out_1(pulse_out_1),
	.pulse_oe_n(pulse_oe_n), .per_flag(per_flag),
	.cap_rise_flag(cap_rise_flag), .cap_fall_flag(cap_fall_flag),
	.chan_running(chan_running),
	.peripheral_dma_request(peripheral_dma_request),
	.adc_trigger(adc_trigger), .irq(irq));
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the pulse and capture group.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
	logic ref_clk, resetn, clk_en, o0, o1, o2, o3, adc, irq, pv;
	logic [7:0] pre_div;
	logic [1:0] pair_comp;
	logic [1:0][7:0] dz_len;
	pcg_pkg::pcg_chan_cfg_t [3:0] cfg;
	logic [3:0] pclr, rclr, fclr, stim, pin_w, oe_n, pf, rf, ff, run, dma;
	logic [3:0][15:0] cv;
	logic [15:0] c0;
	pcg_pkg::pcg_chan_cfg_t cf;
	int num_errors, tests_run, n, h, k;
	pcg_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
		.pre_div(pre_div), .pair_comp(pair_comp), .dz_len(dz_len),
		.chan_cfg(cfg), .per_flag_clr(pclr), .cap_rise_clr(rclr),
		.cap_fall_clr(fclr), .pulse_in(pin_w), .pulse_out_0(o0),
		.pulse_out_1(o1), .pulse_out_2(o2), .pulse_out_3(o3),
		.pulse_oe_n(oe_n), .per_flag(pf), .cap_rise_flag(rf),
		.cap_fall_flag(ff), .cap_value(cv), .chan_running(run),
		.peripheral_dma_request(dma), .adc_trigger(adc), .irq(irq));
	pcg_load_model u_load (.drive({o3, o2, o1, o0}), .oe_n(oe_n),
		.stim(stim), .pin(pin_w));
	// ----
	// Helpers
	// ----
	function automatic pcg_pkg::pcg_chan_cfg_t mk(input logic ar, ud,
		input logic [2:0] d, input logic [15:0] p, u, input logic cap);
		mk = '0;
		mk.enable = 1'b1;
		mk.auto_reload = ar;
		mk.updown = ud;
		mk.div_sel = d;
		mk.period = p;
		mk.duty = u;
		mk.per_ie = !cap;
		mk.adc_trig_en = 1'b1;
		mk.cap_mode = cap;
		mk.cap_rise_lat = cap;
		mk.cap_fall_lat = cap;
		mk.cap_rise_ie = cap;
		mk.dma_en = cap;
	endfunction
	function automatic logic pick(input int s);
		logic [4:0] v;
		v = {adc, o3, o2, o1, o0};
		return v[s];
	endfunction
	task automatic meas(input int s);
		k = 0;
		n = 0;
		h = 0;
		while (pick(s) && k < 9000) begin @(posedge ref_clk); k++; end
		while (!pick(s) && k < 9000) begin @(posedge ref_clk); k++; end
		pv = 1'b1;
		do begin
			h += pick(s);
			pv = pick(s);
			@(posedge ref_clk);
			n++;
		end while (!(pick(s) && !pv) && n < 9000);
	endtask
	task automatic idle();
		cfg <= '0;
		pair_comp <= 2'h0;
		{pclr, rclr, fclr} <= '1;
		repeat (3) @(posedge ref_clk);
		{pclr, rclr, fclr} <= '0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ----
	// Clock, watchdog and tests
	// ----
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#(40 * 60000);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		pre_div = 8'h01;
		pair_comp = 2'h0;
		dz_len = '0;
		cfg = '0;
		{pclr, rclr, fclr, stim} = '0;
		num_errors = 0;
		tests_run = 0;
		repeat (6) @(posedge ref_clk);
		`CHK({oe_n, o0, o1, o2, o3, irq}, 9'h1E0)
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		cfg[0] <= mk(1, 0, 3'h0, 16'h0003, 16'h0001, 0);
		meas(0);
		`CHK(n, 4)
		`CHK(h, 2)
		`CHK({pf[0], irq}, 2'h3)
		idle();
		for (int i = 0; i < 6; i++) begin
			pre_div <= (i == 5) ? 8'hFF : 8'h03;
			cfg[0] <= mk(1, 0, (i == 5) ? 3'h0 : 3'(i), 16'h1, 16'h0, 0);
			meas(0);
			`CHK(n, ((i == 5) ? 510 : 6) << (i % 5))
			idle();
		end
		pre_div <= 8'h01;
		cfg[0] <= mk(0, 0, 3'h0, 16'h0003, 16'h0001, 0);
		k = 0;
		pv = 1'b0;
		repeat (40) begin @(posedge ref_clk); k += (o0 && !pv); pv = o0; end
		`CHK(k, 1)
		`CHK({run[0], pf[0], irq}, 3'h3)
		pclr <= 4'h1;
		@(posedge ref_clk);
		pclr <= 4'h0;
		repeat (2) @(posedge ref_clk);
		`CHK({pf[0], irq}, 2'h0)
		idle();
		dz_len <= {8'h02, 8'h02};
		pair_comp <= 2'h3;
		cfg[0] <= mk(1, 0, 3'h0, 16'h000F, 16'h0007, 0);
		cfg[2] <= mk(1, 0, 3'h0, 16'h000F, 16'h0007, 0);
		k = 0;
		pv = 1'b0;
		while (!(pv && !o1) && k < 200) begin pv = o1; @(posedge ref_clk); k++; end
		n = 0;
		while (!o0 && n < 200) begin @(posedge ref_clk); n++; end
		`CHK(n, 3)
		`CHK({o0, o1}, 2'b10)
		`CHK({o2, o3}, 2'b10)
		idle();
		cfg[3] <= mk(1, 1, 3'h0, 16'h0004, 16'h0002, 0);
		meas(4);
		`CHK(n, 9)
		idle();
		cf = mk(1, 0, 3'h0, 16'h0014, 16'h000F, 0);
		cf.irq_on_duty = 1'b1;
		cfg[1] <= cf;
		repeat (6) @(posedge ref_clk);
		`CHK(pf[1], 1'b0)
		repeat (2) @(posedge ref_clk);
		`CHK({pf[1], irq}, 2'h3)
		clk_en <= 1'b0;
		pclr <= 4'h2;
		repeat (30) @(posedge ref_clk);
		`CHK({pf[1], run[1], o1}, 3'h7)
		clk_en <= 1'b1;
		idle();
		cfg[2] <= mk(1, 0, 3'h0, 16'hFFFF, 16'h0000, 1);
		repeat (4) @(posedge ref_clk);
		`CHK(oe_n[2], 1'b1)
		stim[2] <= 1'b1;
		k = 0;
		repeat (4) begin @(posedge ref_clk); k += dma[2]; end
		`CHK({rf[2], irq}, 2'h3)
		`CHK(k, 1)
		c0 = cv[2];
		rclr[2] <= 1'b1;
		stim[2] <= 1'b0;
		@(posedge ref_clk);
		rclr <= 4'h0;
		repeat (3) @(posedge ref_clk);
		`CHK({rf[2], ff[2], irq}, 3'b010)
		`CHK(c0 - cv[2], 16'h0004)
		tally_and_finish();
	end
endmodule
`default_nettype wire
